/* pst_regs.svh */
/*
 * Timing and field constants of the pipeline stage controller.
 * Assumes inclusion by bare name; holds definitions only.
 */
`ifndef PST_REGS_SVH
`define PST_REGS_SVH

// ***************************************************************
// Field widths
// ***************************************************************
`define PST_REG_W        4
`define PST_CLS_W        4

// ***************************************************************
// Timing counts in pipeline cycles
// ***************************************************************
`define PST_MUL_BUSY_CYC 2'h2
`define PST_MUL_CNT_W    2
`define PST_MUL_CNT_ZERO 2'h0

`endif

/* pst_pkg.sv */
/*
 * Types of the pipeline stage controller: instruction classes and
 * per-class stage properties.
 * Assumes pst_regs.svh is on the include path.
 */
`include "pst_regs.svh"

package pst_pkg;

    // ***************************************************************
    // Instruction classes seen by the sequencer
    // ***************************************************************
    typedef enum logic [`PST_CLS_W-1:0] {
        CL_ALU                = 4'h0,
        CL_LOAD               = 4'h1,
        CL_STORE              = 4'h2,
        CL_WORD_MUL_ACC       = 4'h3,
        CL_SIGNED_WORD_MUL    = 4'h4,
        CL_STORE_SYS_ACC      = 4'h5,
        CL_STORE_SYS_DSP      = 4'h6,
        CL_STORE_SYS_ACC_MEM  = 4'h7,
        CL_STORE_SYS_DSP_MEM  = 4'h8,
        CL_LOAD_SYS_ACC       = 4'h9,
        CL_LOAD_SYS_ACC_MEM   = 4'hA
    } pst_cls_e;

    typedef logic [`PST_REG_W-1:0] pst_reg_t;

    // Every class but the ALU class owns a memory-access stage
    function automatic logic pst_has_ma(input pst_cls_e c);
        return c != CL_ALU;
    endfunction

    function automatic logic pst_has_wb(input pst_cls_e c);
        return c == CL_LOAD || c == CL_STORE_SYS_ACC || c == CL_STORE_SYS_DSP;
    endfunction

    // Classes whose result arrives late enough to stall a dependent reader
    function automatic logic pst_dest_haz(input pst_cls_e c);
        return c == CL_LOAD || c == CL_STORE_SYS_DSP;
    endfunction

    function automatic logic pst_mul_use(input pst_cls_e c);
        return c == CL_WORD_MUL_ACC || c == CL_SIGNED_WORD_MUL ||
               c == CL_STORE_SYS_ACC || c == CL_STORE_SYS_ACC_MEM ||
               c == CL_LOAD_SYS_ACC || c == CL_LOAD_SYS_ACC_MEM;
    endfunction

    function automatic logic pst_mem_write(input pst_cls_e c);
        return c == CL_STORE || c == CL_STORE_SYS_ACC_MEM || c == CL_STORE_SYS_DSP_MEM;
    endfunction

endpackage : pst_pkg

/* pst_mul_busy.sv */
/*
 * Multiplier busy counter: runs a fixed number of cycles after the last
 * memory access of a word multiply-accumulate, whatever the pipeline does.
 * Assumes a single clock and a load pulse from the sequencer.
 */
`timescale 1ns/1ps
`include "pst_regs.svh"

module pst_mul_busy
    import pst_pkg::*;
#(
    parameter logic [`PST_MUL_CNT_W-1:0] BUSY_CYC = `PST_MUL_BUSY_CYC
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic load,
    output logic      busy,
    output logic      tail
);

    logic [`PST_MUL_CNT_W-1:0] cnt_r;
    logic                      tail_r;

    // ***************************************************************
    // Countdown
    // ***************************************************************
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_r <= `PST_MUL_CNT_ZERO;
        end else if (load) begin
            cnt_r <= BUSY_CYC; // RL19
        end else if (cnt_r != `PST_MUL_CNT_ZERO) begin
            cnt_r <= cnt_r - 1'b1; // RL11
        end
    end

    // One state after the multiplier finishes
    always_ff @(posedge clk) begin
        if (!nrst) begin
            tail_r <= 1'b0;
        end else begin
            tail_r <= (cnt_r == 2'h1) && !load;
        end
    end

    assign busy = cnt_r != `PST_MUL_CNT_ZERO;
    assign tail = tail_r;

endmodule // pst_mul_busy

/* pst_pipe_ctrl.sv */
/*
 * Pipeline stage sequencer and stall control for a small RISC core:
 * decode, execute, memory-access and write-back slots, shared memory bus
 * arbitration between fetch and memory access, load-use and multiplier
 * interlocks.
 * Assumes decoded instruction class and register fields arrive from the
 * fetch side on the same clock, only after a fetch request was issued.
 */
// Notes on behaviour
// (RL1) Accumulator half to register: five stages, one-cycle issue, waits on multiplier.
// (RL2) DSP register to general register: stalls a next reader; its access uses the bus.
// (RL3) DSP register store with pre-decrement: four stages, one cycle.
// (RL4) Register transfers: fetch, decode, execute; value passes the ALU.
// (RL5) Loads: five stages; loaded value written in write-back.
// (RL6) Instruction right after a load reading its destination is stalled.
// (RL7) Stores: four stages, no write-back.
// (RL8) Register arithmetic except multiplies: three stages, ALU result in execute.
// (RL9) Word multiply-accumulate: seven stages, two memory accesses, two busy cycles.
// (RL10) Second memory access reads memory and hands operands to the multiplier.
// (RL11) Multiplier stays busy two cycles after the last access, regardless of slots.
// (RL12) Decode after a word multiply-accumulate is held one slot.
// (RL13) Each memory access colliding with fetch splits the slot.
// (RL14) Non-multiplier successor: one slot delay, then normal flow.
// (RL15) Multiplier users right after it meet multiplier contention.
// (RL16) Multiplier access waits until the multiplier finishes, as one slot.
// (RL17) Accumulator store to memory waits one state beyond multiplier end.
// (RL18) Load destination in execute or memory access compared with decode sources.
// (RL19) Busy counter loaded at last access end; multiplier stages wait for zero.
`timescale 1ns/1ps
`include "pst_regs.svh"

module pst_pipe_ctrl
    import pst_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     nrst,
    input  wire logic     ins_valid,
    input  wire pst_cls_e ins_cls,
    input  wire pst_reg_t ins_rd,
    input  wire pst_reg_t ins_rs,
    input  wire logic     ins_rs_use,
    input  wire pst_reg_t ins_rt,
    input  wire logic     ins_rt_use,
    output logic          if_req_r,
    output logic          ma_req_r,
    output logic          ma_we_r,
    output logic          ex_active_r,
    output logic          mul_start_r,
    output logic          mul_busy_r,
    output logic          wb_en_r,
    output pst_reg_t      wb_rd_r,
    output logic          id_stall_r
);

    // ***************************************************************
    // Stage registers
    // ***************************************************************
    logic     id_v_r;
    pst_cls_e id_cls_r;
    pst_reg_t id_rd_r;
    pst_reg_t id_rs_r;
    logic     id_rs_use_r;
    pst_reg_t id_rt_r;
    logic     id_rt_use_r;
    pst_cls_e ex_cls_r;
    pst_reg_t ex_rd_r;
    logic     ma_v_r;
    pst_cls_e ma_cls_r;
    pst_reg_t ma_rd_r;
    logic     ma_ph_r;
    logic     fetch_pend_r;

    logic     mul_busy;
    logic     mul_tail;
    logic     mul_load;
    logic     mul_phase;
    logic     ma_hold;
    logic     ma_last;
    logic     ma_done;
    logic     ma_free;
    logic     ex_go;
    logic     ex_free;
    logic     load_haz;
    logic     macw_hold;
    logic     id_go;
    logic     ma_v_nxt;
    logic     if_req_nxt;

    // ***************************************************************
    // Multiplier interlock
    // ***************************************************************
    pst_mul_busy u_mul_busy (
        .clk  (clk),
        .nrst (nrst),
        .load (mul_load),
        .busy (mul_busy),
        .tail (mul_tail)
    );

    function automatic logic reads_reg(input pst_reg_t r);
        return (id_rs_use_r && id_rs_r == r) || (id_rt_use_r && id_rt_r == r);
    endfunction

    always_comb begin
        // Of the multiply-accumulate only the second access touches the multiplier; other multiplier users touch it in their one access
        mul_phase = ma_v_r && pst_mul_use(ma_cls_r) &&
                    (ma_cls_r != CL_WORD_MUL_ACC || ma_ph_r); // RL10 RL15
        ma_hold   = mul_phase && (mul_busy || // RL16 RL1
                    (ma_cls_r == CL_STORE_SYS_ACC_MEM && mul_tail)); // RL17
        ma_last   = ma_cls_r != CL_WORD_MUL_ACC || ma_ph_r; // RL9
        ma_done   = ma_v_r && !ma_hold && ma_last;
        ma_free   = !ma_v_r || ma_done;
        mul_load  = ma_done && ma_cls_r == CL_WORD_MUL_ACC; // RL19
        ex_go     = ex_active_r && (!pst_has_ma(ex_cls_r) || ma_free);
        ex_free   = !ex_active_r || ex_go;
    end

    // ***************************************************************
    // Decode interlocks
    // ***************************************************************
    always_comb begin
        // Conservative: a pending load in either stage blocks its reader
        load_haz  = (ex_active_r && pst_dest_haz(ex_cls_r) && reads_reg(ex_rd_r)) ||
                    (ma_v_r && pst_dest_haz(ma_cls_r) && reads_reg(ma_rd_r)); // RL6 RL18 RL2
        // The successor can only reach decode behind the first access, so that slot holds too
        macw_hold = (ex_active_r && ex_cls_r == CL_WORD_MUL_ACC) ||
                    (ma_v_r && ma_cls_r == CL_WORD_MUL_ACC && !ma_ph_r); // RL12 RL14
        id_go     = id_v_r && ex_free && !load_haz && !macw_hold;
    end

    // ***************************************************************
    // Bus arbitration: memory access wins, fetch slides to next slot
    // ***************************************************************
    always_comb begin
        ma_v_nxt   = ma_free ? (ex_go && pst_has_ma(ex_cls_r)) : ma_v_r;
        // Overlap the next fetch with an answer only into an empty decode and execute:
        // then the arriving word leaves decode in time and the next answer is never lost
        if_req_nxt = !ma_v_nxt && (fetch_pend_r ? (ins_valid && !id_v_r && !ex_active_r) :
                                                  (!id_v_r || id_go)); // RL13
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            if_req_r <= 1'b0;
        end else begin
            if_req_r <= if_req_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            fetch_pend_r <= 1'b0;
        end else if (if_req_nxt) begin
            fetch_pend_r <= 1'b1;
        end else if (ins_valid) begin
            fetch_pend_r <= 1'b0;
        end
    end

    // ***************************************************************
    // Decode stage
    // ***************************************************************
    always_ff @(posedge clk) begin
        if (!nrst) begin
            id_v_r      <= 1'b0;
            id_cls_r    <= CL_ALU;
            id_rd_r     <= '0;
            id_rs_r     <= '0;
            id_rs_use_r <= 1'b0;
            id_rt_r     <= '0;
            id_rt_use_r <= 1'b0;
        end else if (!id_v_r || id_go) begin
            id_v_r      <= ins_valid;
            id_cls_r    <= ins_cls;
            id_rd_r     <= ins_rd;
            id_rs_r     <= ins_rs;
            id_rs_use_r <= ins_rs_use;
            id_rt_r     <= ins_rt;
            id_rt_use_r <= ins_rt_use;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            id_stall_r <= 1'b0;
        end else begin
            id_stall_r <= id_v_r && !id_go;
        end
    end

    // ***************************************************************
    // Execute stage: ALU classes finish here
    // ***************************************************************
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ex_active_r <= 1'b0;
            ex_cls_r    <= CL_ALU;
            ex_rd_r     <= '0;
        end else if (ex_free) begin
            ex_active_r <= id_go; // RL4 RL8
            ex_cls_r    <= id_cls_r;
            ex_rd_r     <= id_rd_r;
        end
    end

    // ***************************************************************
    // Memory-access stage
    // ***************************************************************
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ma_v_r   <= 1'b0;
            ma_cls_r <= CL_ALU;
            ma_rd_r  <= '0;
            ma_ph_r  <= 1'b0;
        end else if (ma_free) begin
            ma_v_r   <= ma_v_nxt; // RL3 RL7
            ma_cls_r <= ex_cls_r;
            ma_rd_r  <= ex_rd_r;
            ma_ph_r  <= 1'b0;
        end else if (!ma_hold) begin
            ma_ph_r  <= 1'b1; // RL9
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ma_req_r <= 1'b0;
            ma_we_r  <= 1'b0;
        end else begin
            ma_req_r <= ma_v_nxt;
            ma_we_r  <= ma_v_nxt && pst_mem_write(ma_free ? ex_cls_r : ma_cls_r);
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            mul_start_r <= 1'b0;
            mul_busy_r  <= 1'b0;
        end else begin
            mul_start_r <= mul_phase && !ma_hold; // RL10
            mul_busy_r  <= mul_busy;
        end
    end

    // ***************************************************************
    // Write-back stage
    // ***************************************************************
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wb_en_r <= 1'b0;
            wb_rd_r <= '0;
        end else begin
            wb_en_r <= ma_done && pst_has_wb(ma_cls_r); // RL5 RL7
            wb_rd_r <= ma_rd_r;
        end
    end

    // ***************************************************************
    // Checks
    // ***************************************************************
    sequence s_macw_first_ma;
        ma_v_r && ma_cls_r == CL_WORD_MUL_ACC && !ma_ph_r && !ma_hold;
    endsequence

    sequence s_busy_two;
        mul_busy [*2] ##1 !mul_busy;
    endsequence

    property p_alu_no_ma;
        @(posedge clk) disable iff (!nrst) ma_v_r |-> ma_cls_r != CL_ALU;
    endproperty
    a_alu_no_ma: assert property (p_alu_no_ma) else $error("ALU op in access stage"); // RL4

    property p_load_wb;
        @(posedge clk) disable iff (!nrst)
            ma_done && ma_cls_r == CL_LOAD |=> wb_en_r && wb_rd_r == $past(ma_rd_r);
    endproperty
    a_load_wb: assert property (p_load_wb) else $error("load missed write-back"); // RL5

    property p_store_no_wb;
        @(posedge clk) disable iff (!nrst) ma_done && ma_cls_r == CL_STORE |=> !wb_en_r;
    endproperty
    a_store_no_wb: assert property (p_store_no_wb) else $error("store wrote back"); // RL7

    property p_load_use;
        @(posedge clk) disable iff (!nrst)
            id_v_r && ma_v_r && ma_cls_r == CL_LOAD && reads_reg(ma_rd_r)
            |=> id_stall_r && wb_en_r;
    endproperty
    a_load_use: assert property (p_load_use) else $error("load-use not stalled"); // RL6

    property p_macw_two_ma;
        @(posedge clk) disable iff (!nrst) s_macw_first_ma |=> ma_v_r && ma_ph_r;
    endproperty
    a_macw_two_ma: assert property (p_macw_two_ma) else $error("second access lost"); // RL9

    property p_mul_busy_two;
        @(posedge clk) disable iff (!nrst) mul_load |=> s_busy_two;
    endproperty
    a_mul_busy_two: assert property (p_mul_busy_two) else $error("busy not two cycles"); // RL11

    property p_macw_id_hold;
        @(posedge clk) disable iff (!nrst)
            id_v_r && ((ex_active_r && ex_cls_r == CL_WORD_MUL_ACC) ||
                       (ma_v_r && ma_cls_r == CL_WORD_MUL_ACC && !ma_ph_r)) |=> id_stall_r;
    endproperty
    a_macw_id_hold: assert property (p_macw_id_hold) else $error("decode not held"); // RL12

    property p_if_split;
        @(posedge clk) disable iff (!nrst) if_req_r |-> !ma_req_r;
    endproperty
    a_if_split: assert property (p_if_split) else $error("fetch and access share slot"); // RL13

    property p_mul_hold;
        @(posedge clk) disable iff (!nrst) mul_phase && mul_busy |=> !mul_start_r;
    endproperty
    a_mul_hold: assert property (p_mul_hold) else $error("multiplier entered busy"); // RL16

    property p_acc_store_tail;
        @(posedge clk) disable iff (!nrst)
            ma_v_r && ma_cls_r == CL_STORE_SYS_ACC_MEM && mul_tail |=> ma_v_r && !mul_start_r;
    endproperty
    a_acc_store_tail: assert property (p_acc_store_tail) else $error("store left early"); // RL17

endmodule // pst_pipe_ctrl

/* pst_fetch_model.sv */
/*
 * Fetch-side partner of the pipeline controller: answers each fetch
 * request with the next queued decoded instruction.
 * Assumes the bench fills the queue with push and may set slow.
 */
`timescale 1ns/1ps

module pst_fetch_model
    import pst_pkg::*;
(
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic if_req_r,
    output logic      ins_valid,
    output pst_cls_e  ins_cls,
    output pst_reg_t  ins_rd,
    output pst_reg_t  ins_rs,
    output logic      ins_rs_use,
    output pst_reg_t  ins_rt,
    output logic      ins_rt_use
);
    typedef struct packed {
        pst_cls_e c;
        pst_reg_t d;
        pst_reg_t s;
        pst_reg_t t;
    } pst_ins_s;

    pst_ins_s q[$];
    int       slow   = 0;
    int       wait_n = -1;

    task automatic push(input pst_cls_e c, input pst_reg_t d, input pst_reg_t s,
                        input pst_reg_t t);
        q.push_back('{c, d, s, t});
    endtask

    initial begin
        ins_valid  = 1'b0;
        ins_cls    = CL_ALU;
        ins_rd     = 4'h0;
        ins_rs     = 4'h0;
        ins_rt     = 4'h0;
        ins_rs_use = 1'b0;
        ins_rt_use = 1'b0;
    end

    // ********************
    // Answer, at least one cycle after the request
    // ********************
    always @(negedge clk) begin : drive
        pst_ins_s cur;
        if (nrst === 1'b1 && if_req_r !== 1'b1 && wait_n == 0 && q.size() > 0) begin
            cur = q.pop_front();
            ins_valid  <= 1'b1;
            ins_cls    <= cur.c;
            ins_rd     <= cur.d;
            ins_rs     <= cur.s;
            ins_rt     <= cur.t;
            ins_rs_use <= 1'b1;
            ins_rt_use <= 1'b1;
            wait_n     <= -1;
        end else begin
            // Idle register and use lines toggle so a stale one never passes for a live one; ins_cls holds
            ins_valid  <= 1'b0;
            ins_rd     <= ~ins_rd;
            ins_rs     <= ~ins_rs;
            ins_rt     <= ~ins_rt;
            ins_rs_use <= ~ins_rs_use;
            ins_rt_use <= ~ins_rt_use;
            if (nrst !== 1'b1)
                wait_n <= -1;
            else if (if_req_r === 1'b1)
                wait_n <= slow;
            else if (wait_n > 0)
                wait_n <= wait_n - 1;
        end
    end
endmodule // pst_fetch_model

/* tb.sv */
/*
 * Bench of the pipeline controller: each scenario resets it, queues
 * instructions in the fetch model and judges the stage outputs.
 * Assumes the fetch model answers one request at a time.
 */
`timescale 1ns/1ps

module tb
    import pst_pkg::*;
;
    typedef struct {
        int v0, v1, ex_n, ex_first, ex_last, ma_n, ma_first, ma_last;
        int we_n, wb_n, wb_at, st_n, ms_n, ms_at, bz_n, clash;
    } pst_stat_s;

    logic      clk = 1'b0;
    logic      nrst = 1'b0;
    logic      ins_valid, ins_rs_use, ins_rt_use;
    pst_cls_e  ins_cls;
    pst_reg_t  ins_rd, ins_rs, ins_rt, wb_rd_r, wb_rd;
    logic      if_req_r, ma_req_r, ma_we_r, ex_active_r;
    logic      mul_start_r, mul_busy_r, wb_en_r, id_stall_r;
    int        cyc = 0;
    int        fail_count = 0;
    int        check_count = 0;
    pst_stat_s st;

    pst_pipe_ctrl pst_pipe_ctrl_inst (
        .clk(clk), .nrst(nrst), .ins_valid(ins_valid), .ins_cls(ins_cls),
        .ins_rd(ins_rd), .ins_rs(ins_rs), .ins_rs_use(ins_rs_use), .ins_rt(ins_rt),
        .ins_rt_use(ins_rt_use), .if_req_r(if_req_r), .ma_req_r(ma_req_r),
        .ma_we_r(ma_we_r), .ex_active_r(ex_active_r), .mul_start_r(mul_start_r),
        .mul_busy_r(mul_busy_r), .wb_en_r(wb_en_r), .wb_rd_r(wb_rd_r),
        .id_stall_r(id_stall_r));

    pst_fetch_model pst_fetch_model_inst (
        .clk(clk), .nrst(nrst), .if_req_r(if_req_r), .ins_valid(ins_valid),
        .ins_cls(ins_cls), .ins_rd(ins_rd), .ins_rs(ins_rs), .ins_rs_use(ins_rs_use),
        .ins_rt(ins_rt), .ins_rt_use(ins_rt_use));

    initial begin
        forever #4 clk = ~clk;
    end

    // ********************
    // Monitors: outputs are read at the falling edge, where they are settled
    // ********************
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (ins_valid === 1'b1 && st.v0 < 0)
            st.v0 = cyc;
        else if (ins_valid === 1'b1)
            st.v1 = cyc;
        if (cyc == 4000) begin
            fail_count++;
            give_verdict();
        end
    end

    always @(negedge clk) begin
        if (nrst === 1'b1) begin
            if (ex_active_r === 1'b1) begin
                if (st.ex_n == 0)
                    st.ex_first = cyc;
                st.ex_last = cyc;
                st.ex_n++;
            end
            if (ma_req_r === 1'b1) begin
                if (st.ma_n == 0)
                    st.ma_first = cyc;
                st.ma_last = cyc;
                st.ma_n++;
            end
            if (ma_we_r === 1'b1)
                st.we_n++;
            if (wb_en_r === 1'b1) begin
                st.wb_n++;
                st.wb_at = cyc;
                wb_rd = wb_rd_r;
            end
            if (id_stall_r === 1'b1)
                st.st_n++;
            if (mul_start_r === 1'b1)
                st.ms_at = cyc;
            if (mul_busy_r === 1'b1)
                st.bz_n++;
            if (if_req_r === 1'b1 && ma_req_r === 1'b1)
                st.clash++;
        end
    end

    task automatic chk_num(input string what, input int exp, input int got);
        check_count++;
        if (exp != got) begin
            fail_count++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic chk_val(input string what, input logic [3:0] exp, input logic [3:0] got);
        check_count++;
        if (exp !== got) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic do_reset();
        @(negedge clk);
        nrst = 1'b0;
        repeat (3) @(negedge clk);
        chk_val("outputs in reset", 4'h0, {3'h0, |{if_req_r, ma_req_r, ma_we_r,
                ex_active_r, mul_start_r, mul_busy_r, wb_en_r, id_stall_r}});
        nrst = 1'b1;
        st = '{default: 0};
        st.v0 = -1;
        st.ms_at = -1;
    endtask

    // ********************
    // Scenarios
    // ********************
    task automatic s_single();
        pst_cls_e c;
        int       ma_e;
        int       wb_e;
        for (int i = 0; i < 11; i++) begin
            c = pst_cls_e'(i);
            do_reset();
            pst_fetch_model_inst.push(c, 4'h5, 4'h1, 4'h2);
            repeat (20) @(negedge clk);
            ma_e = (c == CL_ALU) ? 0 : (c == CL_WORD_MUL_ACC) ? 2 : 1;
            wb_e = int'(c inside {CL_LOAD, CL_STORE_SYS_ACC, CL_STORE_SYS_DSP});
            chk_num({c.name(), " ex"}, 1, st.ex_n);
            chk_num({c.name(), " ex at"}, st.v0 + 2, st.ex_first);
            chk_num({c.name(), " ma"}, ma_e, st.ma_n);
            if (ma_e > 0)
                chk_num({c.name(), " ma at"}, st.v0 + 3, st.ma_first);
            chk_num({c.name(), " wb"}, wb_e, st.wb_n);
            if (wb_e > 0) begin
                chk_num({c.name(), " wb at"}, st.ma_last + 1, st.wb_at);
                chk_val({c.name(), " wb reg"}, 4'h5, wb_rd);
            end
            chk_num({c.name(), " we"}, int'(c inside {CL_STORE, CL_STORE_SYS_ACC_MEM,
                    CL_STORE_SYS_DSP_MEM}), st.we_n);
            chk_num({c.name(), " clash"}, 0, st.clash);
            if (c == CL_WORD_MUL_ACC) begin
                chk_num("mac start at", st.ma_last + 1, st.ms_at);
                chk_num("mac busy", 2, st.bz_n);
            end
        end
    endtask

    // A late answer lets the producer leave before its reader decodes
    task automatic s_dest(input pst_cls_e p, input pst_reg_t rs, input pst_reg_t rt,
                          input int slow);
        int exp_st;
        exp_st = int'((rs == 4'h3 || rt == 4'h3) && slow == 0 &&
                      p inside {CL_LOAD, CL_STORE_SYS_DSP});
        do_reset();
        pst_fetch_model_inst.slow = slow;
        pst_fetch_model_inst.push(p, 4'h3, 4'h1, 4'h2);
        pst_fetch_model_inst.push(CL_ALU, 4'h9, rs, rt);
        repeat (30) @(negedge clk);
        pst_fetch_model_inst.slow = 0;
        chk_num({p.name(), " reader held"}, exp_st, int'(st.st_n > 0));
        chk_num({p.name(), " reader late"}, exp_st, int'(st.ex_last > st.v1 + 2));
        chk_num({p.name(), " clash"}, 0, st.clash);
    endtask

    task automatic s_mac(input pst_cls_e f, input int gap, output int ma_n);
        do_reset();
        pst_fetch_model_inst.push(CL_WORD_MUL_ACC, 4'h1, 4'h2, 4'h3);
        repeat (gap) pst_fetch_model_inst.push(CL_ALU, 4'hA, 4'hB, 4'hC);
        pst_fetch_model_inst.push(f, 4'h4, 4'h5, 4'h6);
        repeat (40) @(negedge clk);
        ma_n = st.ma_n;
        chk_num({f.name(), " decode held"}, 1, int'(st.st_n > 0));
        chk_num({f.name(), " busy"}, 2, st.bz_n);
        chk_num({f.name(), " clash"}, 0, st.clash);
        chk_num({f.name(), " stretched"}, int'(gap == 0 && f != CL_ALU),
                int'(ma_n > 3));
    endtask

    initial begin
        int a;
        int b;
        do_reset();
        s_single();
        s_dest(CL_LOAD, 4'h3, 4'h8, 0);
        s_dest(CL_LOAD, 4'h7, 4'h3, 0);
        s_dest(CL_LOAD, 4'h7, 4'h8, 0);
        s_dest(CL_LOAD, 4'h3, 4'h8, 2);
        s_dest(CL_STORE_SYS_DSP, 4'h3, 4'h8, 0);
        s_dest(CL_STORE, 4'h3, 4'h8, 0);
        s_dest(CL_STORE_SYS_DSP_MEM, 4'h3, 4'h8, 0);
        s_mac(CL_ALU, 0, a);
        s_mac(CL_SIGNED_WORD_MUL, 2, a);
        s_mac(CL_SIGNED_WORD_MUL, 0, a);
        s_mac(CL_LOAD_SYS_ACC, 0, a);
        s_mac(CL_LOAD_SYS_ACC_MEM, 0, a);
        s_mac(CL_STORE_SYS_ACC, 0, a);
        s_mac(CL_STORE_SYS_ACC_MEM, 0, b);
        chk_num("acc store extra hold", a + 1, b);
        give_verdict();
    end
endmodule // tb
